// ### sar_conversion_sequencer.sv
`timescale 1ns/1ps

// Function
// - resolve 16 bits by successive approximation, msb first, lsb last
// - register feeds result pins and dac; keep or drop on comparator
// - busy rises on trigger and stays high while converting
// - busy releases gated clock; it runs 17 cycles per full conversion
// - trigger trailing edge initializes register and clock gate; status is set on the leading edge
// - first step sets msb trial; next step decides msb, trials bit two
// - decide-then-trial-next repeats until lsb decided at step sixteen
// - after last decision busy clears, marking result valid
// - busy clear regates clock, held low until next conversion
// - result bits change on rising edges of gated clock
// - result pins are negative true, one driven low
// - codes are complementary straight or offset binary by range
// - final result valid at least 20 ns before busy falls
// - short-cycle low after step n ends conversion after bit n
// - 8 to 15 bit short cycles; open input gives full 16 bits
module sar_conversion_sequencer
  import sar_pkg::*;
#(
  parameter int CLK_HZ = SYS_CLK_HZ,
  parameter int BIT_CLK_HZ = GATED_CLK_HZ
) (
  // system
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // host side
  input wire logic convert_start_i,
  output logic busy_o,
  // converter side
  input wire logic comparator_i,
  input wire logic short_cycle_n_i,
  output logic [RESULT_W-1:0] dac_code_o,
  output logic [RESULT_W-1:0] result_o,
  output logic gated_clk_o
);

  // ----------------------------------------------------------------
  // gated clock period in system cycles
  // ----------------------------------------------------------------
  localparam int PERIOD_CYC = CLK_HZ / BIT_CLK_HZ;
  localparam int HIGH_CYC = PERIOD_CYC / 2;
  localparam int PHASE_W = $clog2(PERIOD_CYC);
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PERIOD_CYC - 1);
  localparam logic [PHASE_W-1:0] PHASE_HIGH = PHASE_W'(HIGH_CYC);
  localparam logic [4:0] STEP_LAST = 5'(LAST_STEP);
  localparam logic [2:0] LEAD_LAST = 3'(STATUS_LEAD_CYC - 1);

  typedef struct packed {
    seq_state_type state;
    logic [PHASE_W-1:0] phase;
    logic [4:0] step;
    logic [RESULT_W-1:0] approximation_register;
    logic [2:0] lead;
    logic busy;
    logic gclk;
  } seq_type;

  seq_type seq_reg;
  seq_type seq_next;

  logic start_rise;
  logic start_fall;
  logic comp_level;
  logic short_level;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync start_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i(convert_start_i),
    .level_o(),
    .rise_o(start_rise),
    .fall_o(start_fall)
  );

  pin_sync comp_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i(comparator_i),
    .level_o(comp_level),
    .rise_o(),
    .fall_o()
  );

  pin_sync short_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i(short_cycle_n_i),
    .level_o(short_level),
    .rise_o(),
    .fall_o()
  );

  // ----------------------------------------------------------------
  // bit edit at one gated clock rise
  // ----------------------------------------------------------------
  function automatic logic [RESULT_W-1:0] step_word(
    input logic [RESULT_W-1:0] word,
    input logic [4:0] step,
    input logic keep
  );
    logic [RESULT_W-1:0] res;
    logic [4:0] dec;
    res = word;
    dec = 5'(RESULT_W) - step;
    if (step == 5'h00) begin
      res = FIRST_TRIAL;
    end else begin
      res[dec[3:0]] = keep;
      if (step != STEP_LAST) begin
        res[dec[3:0] - 4'h1] = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg.state)
      ST_IDLE: begin
        if (start_rise) begin
          seq_next.busy = 1'b1;
          seq_next.state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // trailing edge starts the run; clock gate opens here
        if (start_fall) begin
          seq_next.state = ST_RUN;
          seq_next.step = 5'h00;
          seq_next.phase = '0;
          seq_next.gclk = 1'b1;
          seq_next.approximation_register = step_word(
            seq_reg.approximation_register, 5'h00, 1'b0);
        end
      end
      ST_RUN: begin
        // comparator settles a whole period before it is judged
        if (seq_reg.phase == PHASE_LAST) begin
          if (seq_reg.step == STEP_LAST || !short_level) begin
            seq_next.state = ST_FINISH;
            seq_next.lead = '0;
          end else begin
            seq_next.step = seq_reg.step + 5'h01;
            seq_next.phase = '0;
            seq_next.gclk = 1'b1;
            seq_next.approximation_register = step_word(
              seq_reg.approximation_register, seq_reg.step + 5'h01,
              comp_level);
          end
        end else begin
          seq_next.phase = seq_reg.phase + 1'b1;
          if (seq_reg.phase + 1'b1 == PHASE_HIGH) begin
            seq_next.gclk = 1'b0;
          end
        end
      end
      ST_FINISH: begin
        // hold result steady before busy drops
        seq_next.gclk = 1'b0;
        if (seq_reg.lead == LEAD_LAST) begin
          seq_next.busy = 1'b0;
          seq_next.state = ST_IDLE;
        end else begin
          seq_next.lead = seq_reg.lead + 3'h1;
        end
      end
      default: begin
        seq_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      seq_reg <= '0;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // codes are complementary; the analog range picks binary flavour
  assign dac_code_o = seq_reg.approximation_register;
  assign result_o = ~seq_reg.approximation_register;
  assign busy_o = seq_reg.busy;
  assign gated_clk_o = seq_reg.gclk;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [4:0] rise_cnt;
  logic gclk_d;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rise_cnt <= 5'h00;
      gclk_d <= 1'b0;
    end else begin
      gclk_d <= seq_reg.gclk;
      if (seq_reg.state == ST_IDLE) begin
        rise_cnt <= 5'h00;
      end else if (seq_reg.gclk && !gclk_d) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  sequence s_stop_seen;
    seq_reg.state == ST_RUN && seq_reg.phase == PHASE_LAST && !short_level;
  endsequence

  sequence s_finish_quiet;
    !gated_clk_o [*4] ##1 !busy_o;
  endsequence

  a_clock_gated: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !busy_o |-> !gated_clk_o)
    else $error("gated clock high while not busy");

  a_busy_on_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (seq_reg.state == ST_IDLE && start_rise) |=> busy_o)
    else $error("busy did not rise on trigger");

  a_result_on_edge: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $changed(result_o) |-> $rose(gated_clk_o))
    else $error("result changed off a clock rise");

  a_edge_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(busy_o) |-> rise_cnt == seq_reg.step + 5'h01)
    else $error("gated clock rise count wrong");

  a_lead_time: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(busy_o) |-> $past(result_o, 4) == result_o)
    else $error("result not stable before busy fell");

  a_first_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (seq_reg.state == ST_ARMED && start_fall) |=>
      dac_code_o == FIRST_TRIAL && gated_clk_o)
    else $error("first trial word wrong");

  a_trial_order: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(gated_clk_o) && seq_reg.step != STEP_LAST |->
      (dac_code_o & ((FIRST_TRIAL >> seq_reg.step) - 16'h0001)) == 16'h0000)
    else $error("bits below the trial bit not clear");

  a_short_cycle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_stop_seen |=> s_finish_quiet)
    else $error("short cycle did not end conversion");

  a_full_cycle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (seq_reg.state == ST_RUN && seq_reg.step == STEP_LAST &&
     seq_reg.phase == PHASE_LAST) |=> seq_reg.state == ST_FINISH)
    else $error("conversion ran past the lsb");

endmodule // sar_conversion_sequencer

// ### sar_pkg.sv
package sar_pkg;

  // ----------------------------------------------------------------
  // word layout and sequence
  // ----------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int LAST_STEP = 16;
  localparam logic [15:0] FIRST_TRIAL = 16'h8000;
  localparam logic [15:0] CLEAR_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int SYS_PERIOD_NS = 5;
  localparam int GATED_CLK_HZ = 1_600_000;
  localparam int STATUS_LEAD_NS = 20;
  // least time, rounded up to whole system cycles
  localparam int STATUS_LEAD_CYC =
    (STATUS_LEAD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ----------------------------------------------------------------
  // sequencer states, gray along idle-armed-run-finish
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN = 2'h3,
    ST_FINISH = 2'h2
  } seq_state_type;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps

module pin_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // pin side
  input wire logic pin_i,
  // synchronised side
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_type;

  sync_type sync_reg;
  sync_type sync_next;

  // meta is read only by the second stage
  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = pin_i;
    sync_next.sync = sync_reg.meta;
    sync_next.last = sync_reg.sync;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign level_o = sync_reg.sync;
  assign rise_o = sync_reg.sync & ~sync_reg.last;
  assign fall_o = ~sync_reg.sync & sync_reg.last;

endmodule // pin_sync

// ### host_model.sv
`timescale 1ns/1ps

module host_model (
  // clock
  input wire logic clk_sys_i,
  // device side
  input wire logic busy_i,
  input wire logic [15:0] dac_code_i,
  output logic convert_start_o,
  output logic comparator_o,
  // host copies of the result
  output logic [15:0] latched_o,
  output logic [15:0] twos_o
);
  // --------------------------------------------------
  // analog input and comparator
  // --------------------------------------------------
  logic [15:0] target;

  initial begin
    convert_start_o = 1'b0;
    target = 16'h0000;
    latched_o = 16'hFFFF;
  end

  // trial kept while it does not exceed the input
  assign comparator_o = (dac_code_i <= target);

  // --------------------------------------------------
  // host side
  // --------------------------------------------------
  always @(negedge busy_i) begin
    latched_o <= ~dac_code_i;
  end

  // bipolar users flip the msb for twos-complement
  assign twos_o = {~latched_o[15], latched_o[14:0]};

  task automatic pulse(input logic [15:0] value);
    target = value;
    @(posedge clk_sys_i);
    convert_start_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    convert_start_o <= 1'b0;
  endtask

  // no new trigger until busy has fallen
  task automatic convert(input logic [15:0] value);
    pulse(value);
    while (busy_i) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
  endtask
endmodule // host_model

// ### sar_conversion_sequencer_tb.sv
`timescale 1ns/1ps

module sar_conversion_sequencer_tb;
  import sar_pkg::*;

  logic clk_sys_i;
  logic reset_i;
  logic convert_start_i;
  logic comparator_i;
  logic short_cycle_n_i;
  logic busy_o;
  logic gated_clk_o;
  logic [15:0] dac_code_o;
  logic [15:0] result_o;
  logic [15:0] latched;
  logic [15:0] twos;
  int width_sel;
  int err_total;
  int checked;
  int cycles;
  int rises;
  int stable;
  logic gclk_q;
  logic busy_q;
  logic [15:0] res_q;
  logic [23:0] notes[$];
  int widths[7] = '{8, 10, 12, 13, 14, 15, 16};

  // --------------------------------------------------
  // clock, device and host
  // --------------------------------------------------
  initial clk_sys_i = 1'b0;
  always #2.5 clk_sys_i = ~clk_sys_i;

  // short-cycle pin tied to result pin n+1, open for 16 bits
  assign short_cycle_n_i =
    (width_sel >= 16) ? 1'b1 : result_o[15-width_sel];

  sar_conversion_sequencer #(
    .BIT_CLK_HZ(20_000_000)
  ) DUT (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .convert_start_i(convert_start_i),
    .busy_o(busy_o),
    .comparator_i(comparator_i),
    .short_cycle_n_i(short_cycle_n_i),
    .dac_code_o(dac_code_o),
    .result_o(result_o),
    .gated_clk_o(gated_clk_o)
  );

  host_model host (
    .clk_sys_i(clk_sys_i),
    .busy_i(busy_o),
    .dac_code_i(dac_code_o),
    .convert_start_o(convert_start_i),
    .comparator_o(comparator_i),
    .latched_o(latched),
    .twos_o(twos)
  );

  // --------------------------------------------------
  // checking
  // --------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // {gated clock rises, result pins}; trial bit n+1 stays set
  function automatic logic [23:0] expect_of(input logic [15:0] t,
                                             input int n);
    logic [15:0] top;
    top = ~(16'hFFFF >> n);
    if (n >= 16)
      return {8'h11, ~t};
    return {8'(n + 1), ~((t & top) | (16'h8000 >> n))};
  endfunction

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rises = 0;
      stable = 0;
    end else begin
      if (gated_clk_o && !gclk_q)
        rises++;
      check({8'h00, result_o}, {8'h00, ~dac_code_o});
      if (!busy_o)
        check({23'h0, gated_clk_o}, 24'h0);
      if (result_o !== res_q) begin
        check({23'h0, gated_clk_o && !gclk_q}, 24'h1);
        stable = 0;
      end else
        stable++;
      if (!busy_o && busy_q) begin
        if (notes.size() == 0)
          check(24'hFFFFFF, 24'h0);
        else
          check({8'(rises), result_o}, notes.pop_front());
        check({23'h0, stable >= STATUS_LEAD_CYC}, 24'h1);
        rises = 0;
      end
    end
    gclk_q = gated_clk_o;
    busy_q = busy_o;
    res_q = result_o;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end

  // --------------------------------------------------
  // stimulus
  // --------------------------------------------------
  initial begin
    logic [15:0] t;
    reset_i = 1'b1;
    width_sel = 16;
    void'($urandom(66673));
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    foreach (widths[i]) begin
      t = 16'($urandom);
      width_sel = widths[i];
      notes.push_back(expect_of(t, widths[i]));
      host.convert(t);
    end
    width_sel = 16;
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      notes.push_back(expect_of(t, 16));
      host.convert(t);
      check({8'h00, latched}, {8'h00, ~t});
      check({8'h00, twos}, {8'h00, ~(t - 16'h8000)});
    end
    // reset in mid-conversion leaves pins idle
    host.pulse(16'h5A5A);
    repeat (60) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({6'h0, busy_o, gated_clk_o, result_o}, 24'h00FFFF);
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    t = 16'($urandom);
    notes.push_back(expect_of(t, 16));
    host.convert(t);
    check({8'h00, 8'(notes.size())}, 24'h0);
    summarize();
  end
endmodule // sar_conversion_sequencer_tb
